// ==== slpo_host.sv ====
// Host model: serial data, shift clock and latch clock paced by the system clock
`timescale 1ns/10ps

module slpo_host (
   // Pacing clock
   input wire logic clk,
   // Host pins
   output logic ser_in,
   output logic shift_clk,
   output logic latch_clk
);
   // Link clocks stand still low between frames
   initial begin
      ser_in = 1'b0;
      shift_clk = 1'b0;
      latch_clk = 1'b0;
   end

   // Half of the 320 ns link period
   task automatic half();
      repeat (4) @(posedge clk);
   endtask

   // Msb first, so the first bit ends in the eighth stage
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         ser_in <= b[i];
         shift_clk <= 1'b0;
         half();
         shift_clk <= 1'b1;
         half();
      end
      shift_clk <= 1'b0;
      ser_in <= ~b[0]; // Released line shows the inverse, never a held value
   endtask

   // One latch rise after the last shift rise
   task automatic pulse_latch();
      latch_clk <= 1'b1;
      half();
      latch_clk <= 1'b0;
      half();
   endtask
endmodule // slpo_host

// ==== slpo_pkg.sv ====
// Package for the serial-in, latched parallel-out shifter: widths, depths, reset values, pin bundle
package slpo_pkg;
   localparam int STAGES = 8;                 // Shift stages and held word width
   localparam int FIFO_DEPTH = 8;             // Words between the chain and the held word
   localparam int SYNC_STAGES = 2;            // Flip-flops on every pin input
   localparam logic [7:0] CHAIN_RST = 8'h00;  // Stage chain value while cleared
   localparam logic [7:0] HELD_RST = 8'h00;   // Held word value after system reset
   localparam logic [2:0] SYNC_RST = 3'h0;    // Synchroniser value after system reset
   localparam logic SYNC_OE_RST = 1'b1;       // Output enable idles disabled

   // Pins that the host drives, sampled together
   typedef struct packed {
      logic ser_in;
      logic shift_clk;
      logic latch_clk;
   } slpo_pins_t;

   // Parallel output bundle: held data and a separate active-low output enable
   typedef struct packed {
      logic [7:0] data;
      logic oe_n;
   } slpo_par_t;
endpackage

// ==== slpo_top.sv ====
// Serial-in shift chain, transfer FIFO, held word and parallel outputs with a separate output enable
`timescale 1ns/10ps

module slpo_fifo #(
   parameter int WIDTH = slpo_pkg::STAGES,
   parameter int DEPTH = slpo_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic push, pop;

   // Wrapping pointer step, shared by both pointers
   function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
      step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // Honest full and empty from the occupancy count
   assign in_ready = (cnt_reg != CW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count next values
   always_comb begin
      wr_next = push ? step(wr_reg) : wr_reg;
      rd_next = pop ? step(rd_reg) : rd_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = CW'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = CW'(cnt_reg - 1'b1);
      end
   end

   // Pointer and count registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage has no reset; contents are only read while counted valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   // Checks
   // A refused push must leave the count and the write pointer where they were
   property p_full_refuse;
      @(posedge clk) disable iff (!rst_n)
      in_valid && !in_ready && !out_ready |=> cnt_reg == CW'(DEPTH) && $stable(wr_reg);
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("Full queue took a word");
endmodule // slpo_fifo

module slpo_top (
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host pins
   input wire logic ser_in,
   input wire logic shift_clk,
   input wire logic latch_clk,
   input wire logic stage_clr_n,
   input wire logic out_en_n,
   // Drain control from local logic
   input wire logic held_stall,
   output logic xfer_ready,
   // Outputs
   output logic [7:0] parallel_pins,
   output logic parallel_pins_oe_n,
   output logic cascade_out
);
   localparam int N = slpo_pkg::STAGES;

   slpo_pkg::slpo_pins_t pins_in;
   slpo_pkg::slpo_pins_t s1_reg, s2_reg, prev_reg;
   slpo_pkg::slpo_par_t par_reg, par_next;
   logic oe1_reg, oe2_reg;
   logic [N-1:0] stage_chain, chain_next;
   logic [N-1:0] held_word, held_next;
   logic shift_rise, latch_rise;
   logic fifo_valid;
   logic [N-1:0] fifo_data;
   logic pop;
   logic clr_any_n, clr1_n_reg, clr2_n_reg;

   assign pins_in = '{ser_in: ser_in, shift_clk: shift_clk, latch_clk: latch_clk};

   // Two-flop synchronisers; prev_reg reads only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= slpo_pkg::SYNC_RST;
         s2_reg <= slpo_pkg::SYNC_RST;
         prev_reg <= slpo_pkg::SYNC_RST;
         oe1_reg <= slpo_pkg::SYNC_OE_RST;
         oe2_reg <= slpo_pkg::SYNC_OE_RST;
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
         prev_reg <= s2_reg;
         oe1_reg <= out_en_n;
         oe2_reg <= oe1_reg;
      end
   end

   // Rising edge of a sampled pin, shared by both host clocks
   function automatic logic rose(input logic now_lvl, input logic was_lvl);
      rose = now_lvl & ~was_lvl;
   endfunction

   // Edge finders on the sampled host clocks
   assign shift_rise = rose(s2_reg.shift_clk, prev_reg.shift_clk);
   assign latch_rise = rose(s2_reg.latch_clk, prev_reg.latch_clk);

   // Chain next value: data into stage one, the rest move up
   always_comb begin
      chain_next = stage_chain;
      if (shift_rise) begin
         chain_next = {stage_chain[N-2:0], s2_reg.ser_in};
      end
   end

   // Stage clear falls through at once but is released through two flops,
   // so a release never races the clock; a shift in those two cycles is lost
   assign clr_any_n = rst_n & stage_clr_n;

   always_ff @(posedge clk or negedge clr_any_n) begin
      if (!clr_any_n) begin
         clr1_n_reg <= 1'b0;
         clr2_n_reg <= 1'b0;
      end else begin
         clr1_n_reg <= 1'b1;
         clr2_n_reg <= clr1_n_reg;
      end
   end

   // Stage chain; the clear acts with no clock edge
   always_ff @(posedge clk or negedge clr2_n_reg) begin
      if (!clr2_n_reg) begin
         stage_chain <= slpo_pkg::CHAIN_RST;
      end else begin
         stage_chain <= chain_next;
      end
   end

   // Latch transfers queue here; a full queue refuses them and shows it on xfer_ready
   slpo_fifo #(
      .WIDTH(N),
      .DEPTH(slpo_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(latch_rise),
      .in_ready(xfer_ready),
      .in_data(stage_chain),
      .out_valid(fifo_valid),
      .out_ready(~held_stall),
      .out_data(fifo_data)
   );
   assign pop = fifo_valid & ~held_stall;

   // Held word changes only on a transfer; stage clear does not reach it
   always_comb begin
      held_next = pop ? fifo_data : held_word;
      par_next.data = held_next;
      par_next.oe_n = oe2_reg;
   end

   // Held word and output registers; only system reset clears them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_word <= slpo_pkg::HELD_RST;
         par_reg <= '{data: slpo_pkg::HELD_RST, oe_n: slpo_pkg::SYNC_OE_RST};
      end else begin
         held_word <= held_next;
         par_reg <= par_next;
      end
   end

   // Pins always carry the held data; oe_n leaves separately on parallel_pins_oe_n and nothing here floats them
   assign parallel_pins = par_reg.data;
   assign parallel_pins_oe_n = par_reg.oe_n;
   assign cascade_out = stage_chain[N-1];

   // Checks
   sequence s_shift_clean;
      shift_rise && clr2_n_reg ##1 clr2_n_reg;
   endsequence

   sequence s_idle_clean;
      !shift_rise && clr2_n_reg ##1 clr2_n_reg;
   endsequence

   property p_shift;
      @(posedge clk) disable iff (!rst_n)
      s_shift_clean |-> stage_chain == {$past(stage_chain[N-2:0]), $past(s2_reg.ser_in)};
   endproperty
   a_shift: assert property (p_shift) else $error("Shift did not move chain");

   property p_capture;
      @(posedge clk) disable iff (!rst_n)
      s_shift_clean |-> stage_chain[0] == $past(ser_in, 3);
   endproperty
   a_capture: assert property (p_capture) else $error("Serial pin not captured");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      s_idle_clean |-> $stable(stage_chain);
   endproperty
   a_hold: assert property (p_hold) else $error("Chain changed without shift");

   property p_clear;
      @(posedge clk) disable iff (!rst_n)
      !stage_clr_n |-> stage_chain == slpo_pkg::CHAIN_RST && !cascade_out;
   endproperty
   a_clear: assert property (p_clear) else $error("Chain not cleared");

   property p_clear_async;
      @(posedge clk) disable iff (!rst_n)
      $fell(stage_clr_n) |-> stage_chain == slpo_pkg::CHAIN_RST;
   endproperty
   a_clear_async: assert property (p_clear_async) else $error("Clear waited for a clock");

   property p_cascade;
      @(posedge clk) disable iff (!rst_n)
      s_shift_clean |-> cascade_out == $past(stage_chain[N-2]);
   endproperty
   a_cascade: assert property (p_cascade) else $error("Cascade not last stage");

   sequence s_fast_xfer;
      latch_rise && xfer_ready && !fifo_valid && !held_stall ##1 !held_stall;
   endsequence

   property p_xfer;
      @(posedge clk) disable iff (!rst_n)
      s_fast_xfer |-> ##1 held_word == $past(stage_chain, 2);
   endproperty
   a_xfer: assert property (p_xfer) else $error("Latch transfer lost");

   property p_pins_word;
      @(posedge clk) disable iff (!rst_n)
      s_fast_xfer |-> ##1 parallel_pins == $past(stage_chain, 2);
   endproperty
   a_pins_word: assert property (p_pins_word) else $error("Pins differ from stages");

   property p_held_stable;
      @(posedge clk) disable iff (!rst_n)
      !fifo_valid && !latch_rise |=> ##1 $stable(held_word);
   endproperty
   a_held_stable: assert property (p_held_stable) else $error("Held word moved");

   property p_clear_keeps;
      @(posedge clk) disable iff (!rst_n)
      !stage_clr_n && !pop |=> $stable(held_word) && $stable(parallel_pins);
   endproperty
   a_clear_keeps: assert property (p_clear_keeps) else $error("Clear touched held word");

   property p_oe;
      @(posedge clk) disable iff (!rst_n)
      $changed(out_en_n) ##1 $stable(out_en_n) ##1 $stable(out_en_n)
         |=> parallel_pins_oe_n == $past(out_en_n, 3);
   endproperty
   a_oe: assert property (p_oe) else $error("Enable not followed");
endmodule // slpo_top

// ==== slpo_top_test.sv ====
// Self-checking testbench for the latched parallel-out shifter
`timescale 1ns/10ps

module slpo_top_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic stage_clr_n = 1'b1;
   logic out_en_n = 1'b1;
   logic held_stall = 1'b0;
   logic ser_in, shift_clk, latch_clk, xfer_ready, parallel_pins_oe_n, cascade_out;
   logic [7:0] parallel_pins;
   int num_errors = 0;
   int comparisons = 0;

`define CHK(got, exp) check_eq(8'(got), 8'(exp))

   // 25 MHz clock
   always #20 clk = ~clk;

   slpo_host u_host (.clk(clk), .ser_in(ser_in), .shift_clk(shift_clk), .latch_clk(latch_clk));

   slpo_top u_dut (
      .clk(clk), .rst_n(rst_n), .ser_in(ser_in), .shift_clk(shift_clk), .latch_clk(latch_clk),
      .stage_clr_n(stage_clr_n), .out_en_n(out_en_n), .held_stall(held_stall),
      .xfer_ready(xfer_ready), .parallel_pins(parallel_pins),
      .parallel_pins_oe_n(parallel_pins_oe_n), .cascade_out(cascade_out)
   );

   // Case equality so an unknown never passes
   task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Idle values straight after reset
   task automatic t_reset();
      `CHK(parallel_pins, 8'h00);
      `CHK(cascade_out, 1'b0);
      `CHK(parallel_pins_oe_n, 1'b1);
      `CHK(xfer_ready, 1'b1);
   endtask

   // Shift a word, latch it, see it on the pins uninverted
   task automatic t_shift_latch();
      out_en_n <= 1'b0;
      u_host.send_byte(8'ha5);
      `CHK(cascade_out, 1'b1);
      u_host.pulse_latch();
      `CHK(parallel_pins, 8'ha5);
      `CHK(parallel_pins_oe_n, 1'b0);
      // A second word reaches the cascade output, but the pins keep the first word until a latch
      u_host.send_byte(8'h3c);
      `CHK(cascade_out, 1'b0);
      `CHK(parallel_pins, 8'ha5);
   endtask

   // Raising out_en_n keeps the held word and the cascade output
   task automatic t_enable();
      out_en_n <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(parallel_pins_oe_n, 1'b1);
      `CHK(cascade_out, 1'b0);
      out_en_n <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK(parallel_pins_oe_n, 1'b0);
      `CHK(parallel_pins, 8'ha5);
   endtask

   // Clear acts before the next edge and spares the held word
   task automatic t_clear();
      u_host.send_byte(8'hff);
      `CHK(cascade_out, 1'b1);
      stage_clr_n <= 1'b0;
      #5;
      `CHK(cascade_out, 1'b0);
      repeat (3) @(posedge clk);
      `CHK(parallel_pins, 8'ha5);
      stage_clr_n <= 1'b1;
      @(posedge clk);
      u_host.pulse_latch();
      `CHK(parallel_pins, 8'h00);
   endtask

   // Stalled drain: eight words fill the buffer, a ninth latch is dropped
   task automatic t_fifo();
      held_stall <= 1'b1;
      for (int i = 1; i <= 9; i++) begin
         u_host.send_byte(8'(i));
         u_host.pulse_latch();
      end
      `CHK(xfer_ready, 1'b0);
      `CHK(parallel_pins, 8'h00);
      held_stall <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK(parallel_pins, 8'h08);
      `CHK(xfer_ready, 1'b1);
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      t_shift_latch();
      t_enable();
      t_clear();
      t_fifo();
      final_report();
   end

   // Watchdog sized well above the expected run
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      final_report();
   end
endmodule // slpo_top_test
